// *** ilu_pkg.sv ***
package ilu_pkg;

	// Register addresses on the special-function area.
	localparam logic [7:0] EN_LOW_ADDR      = 8'h3A;
	localparam logic [7:0] EN_HIGH_ADDR     = 8'h3B;
	localparam logic [7:0] PEND_LOW_ADDR    = 8'h3C;
	localparam logic [7:0] PEND_HIGH_ADDR   = 8'h3D;
	localparam logic [7:0] SHARED_SEL_ADDR  = 8'h3E;
	localparam logic [7:0] TRAP_CTRL_ADDR   = 8'h38;

	// Field positions.
	localparam int MASTER_EN_BIT   = 0;
	localparam int SEL_L8_BIT      = 7;
	localparam int SEL_L9_BIT      = 6;
	localparam int SEL_L13_BIT     = 2;
	localparam int SEL_L14_BIT     = 1;
	localparam int SEL_L15_BIT     = 0;
	localparam int EXT0_EN_BIT     = 0;
	localparam int RAM_TRAP_EN_BIT = 1;
	localparam int WDOG_RESP_BIT   = 2;
	localparam int TRAP_RESP_BIT   = 3;

	// Reset values.
	localparam logic [15:0] PEND_RESET       = 16'h0000;
	localparam logic [15:4] LEVEL_EN_RESET   = 12'h000;
	localparam logic        MASTER_EN_RESET  = 1'b0;
	localparam logic [7:0]  SHARED_SEL_RESET = 8'h00;
	localparam logic [3:0]  TRAP_CTRL_RESET  = 4'hC;
	localparam logic [7:0]  SHARED_SEL_MASK  = 8'hC7;

	// Vectors: a latched level n uses VECTOR_TOP minus two times n.
	localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
	localparam logic [15:0] VECTOR_TOP   = 16'hFFFE;
	localparam logic [15:0] SOFT_VECTOR  = 16'hFFFC;

	// Source levels.
	localparam int LVL_SOFT  = 0;
	localparam int LVL_ATRAP = 2;
	localparam int LVL_WDOG  = 3;
	localparam int LVL_EXT0  = 4;
	localparam int LVL_FIRST = 2;
	localparam int LVL_LAST  = 15;

	// Peripheral request positions.
	localparam int P_TC4  = 0;
	localparam int P_TC5  = 1;
	localparam int P_TBT  = 2;
	localparam int P_TC1  = 3;
	localparam int P_TC3  = 4;
	localparam int P_TC6  = 5;
	localparam int P_TC2  = 6;
	localparam int P_SIO1 = 7;
	localparam int P_TRX  = 8;
	localparam int P_ADC  = 9;
	localparam int P_SIO2 = 10;
	localparam int PERIPH_COUNT = 11;

	// External pins; pins 0 and 5 request on a falling level.
	localparam int PIN_COUNT = 6;
	localparam logic [5:0] PIN_ACTIVE_LOW = 6'h21;

	// Fetch areas that trip the address trap.
	localparam logic [15:0] SFR_AREA_LO  = 16'h0000;
	localparam logic [15:0] SFR_AREA_HI  = 16'h003F;
	localparam logic [15:0] RAM_AREA_LO  = 16'h0040;
	localparam logic [15:0] RAM_AREA_HI  = 16'h0F7F;
	localparam logic [15:0] BANK_AREA_LO = 16'h0F80;
	localparam logic [15:0] BANK_AREA_HI = 16'h0FFF;

	// Trap reset length: at most 24 periods of fc, counted on i_mclk.
	localparam int MCLK_HZ             = 20_000_000;
	localparam int FC_HZ               = 20_000_000;
	localparam int TRAP_RESET_FC       = 24;
	localparam int TRAP_RESET_CYC_INT  = (TRAP_RESET_FC * (MCLK_HZ / 1000)) / (FC_HZ / 1000);
	localparam logic [4:0] TRAP_RESET_CYCLES =
		(TRAP_RESET_CYC_INT < 1) ? 5'h01 : 5'(TRAP_RESET_CYC_INT);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_HOLD = 2'b10
	} trap_state_t;

endpackage

// *** ilu_pick_if.sv ***
`timescale 1ns/1ns
interface ilu_pick_if;
	logic [15:0] candidates;
	logic        found;
	logic [3:0]  level;

	modport requester (output candidates, input found, input level);
	modport picker    (input candidates, output found, output level);
endinterface

// *** priority_picker.sv ***
`timescale 1ns/1ns
module priority_picker
	import ilu_pkg::*;
(
	ilu_pick_if.picker pick
);

	function automatic logic [3:0] lowest_set(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	assign pick.found = |pick.candidates;
	assign pick.level = lowest_set(pick.candidates);

endmodule

// *** pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync
	import ilu_pkg::*;
(
	// Clock and reset.
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// Pins and request pulses.
	input  wire logic [5:0]       i_pin,
	output logic      [5:0]       o_edge
);

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
			logic s1;
			logic s2;
			logic s3;
			logic held;
			wire  agree  = (s2 == s3);
			wire  active = s3 ^ PIN_ACTIVE_LOW[g];
			always_ff @(posedge i_mclk or posedge i_rst) begin
				if (i_rst) begin
					s1   <= PIN_ACTIVE_LOW[g];
					s2   <= PIN_ACTIVE_LOW[g];
					s3   <= PIN_ACTIVE_LOW[g];
					held <= PIN_ACTIVE_LOW[g];
					o_edge[g] <= 1'b0;
				end else if (i_ce) begin
					s1 <= i_pin[g];
					s2 <= s1;
					s3 <= s2;
					if (agree && (s3 != held)) begin
						held <= s3;
					end
					o_edge[g] <= agree && (s3 != held) && active;
				end
			end
		end
	endgenerate

endmodule

// *** interrupt_latch_unit.sv ***
// Contract
// [R1] Twenty-one sources besides reset, each with its vector; nesting by priority.
// [R2] Software, bad-opcode, address and watchdog traps are non-maskable; others maskable.
// [R3] A source request sets its latch; a set, enabled latch requests the core.
// [R4] Core acceptance clears the accepted latch at once.
// [R5] Every reset clears all pending latches.
// [R6] Latches at 003CH low and 003DH high; writing zero clears that bit.
// [R7] Writing one never sets a latch; only hardware sets latches.
// [R8] Reading the latches returns current request state.
// [R9] Software and bad-opcode traps have no latch; every other level has one.
// [R10] Software never clears trap latches and writes ones there when clearing.
// [R11] Software clears latches by plain load, never read-modify-write.
// [R12] Maskable accepted only with master and level enables both set.
// [R13] Simultaneous requests accepted in fixed order; non-maskables unordered among themselves.
// [R14] Reset FFFE, soft traps FFFC, address trap FFFA, watchdog FFF8.
// [R15] External 0 uses FFF6 and also needs its pin enable.
// [R16] Levels 5 to 15 use FFF4 down to FFE0; smaller priority wins.
// [R17] Five shared levels; selector bit routes one source, other cannot set latch.
// [R18] Fetch from special, bank or enabled RAM area raises trap; reset within 24/fc.
// [R19] Address trap response selects reset after reset; clear it for interrupt.
// [R20] Watchdog response selects reset after reset; clear it for interrupt.
// [R21] Software masks all before changing enables or latches, then unmasks.
// [R22] Acceptance stacks master enable then clears it; return restores stacked value.
// [R23] Master enable is bit 0 at 003AH, read-write, reset to zero.
// [R24] Non-maskable sources ignore master and level enables.
// [R25] Highest acceptable request and its vector are presented until accepted.
`timescale 1ns/1ns
module interrupt_latch_unit
	import ilu_pkg::*;
(
	// Clock, reset, enable.
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// Special-function register port.
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	// Core fetch and control.
	input  wire logic        i_fetch_valid,
	input  wire logic [15:0] i_fetch_addr,
	input  wire logic        i_software_trap_source,
	input  wire logic        i_bad_opcode_source,
	input  wire logic        i_mask_all_op,
	input  wire logic        i_unmask_all_op,
	input  wire logic        i_return_from_interrupt,
	input  wire logic        i_stacked_master_enable,
	input  wire logic        i_irq_accept,
	// Request sources.
	input  wire logic [5:0]  i_int_pin,
	input  wire logic [10:0] i_periph_req,
	input  wire logic        i_wdog_trap_source,
	// Core request and trap reset.
	output logic             o_irq_valid,
	output logic      [15:0] o_irq_vector,
	output logic      [3:0]  o_irq_level,
	output logic             o_master_accept_enable,
	output logic             o_trap_reset
);

	logic [15:0] pending_request_latch;
	logic [15:4] level_accept_enable;
	logic [7:0]  shared_source_selector;
	logic [3:0]  watchdog_control_one;
	trap_state_t trap_state;
	logic [4:0]  trap_count;

	logic [5:0]  pin_edge;
	ilu_pick_if  pick ();

	pin_sync u_pin_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_ce   (i_ce),
		.i_pin  (i_int_pin),
		.o_edge (pin_edge)
	);

	priority_picker u_picker (
		.pick (pick)
	);

	function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// Register decode.
	wire wr_en_low    = i_sfr_wr && (i_sfr_addr == EN_LOW_ADDR);
	wire wr_en_high   = i_sfr_wr && (i_sfr_addr == EN_HIGH_ADDR);
	wire wr_pend_low  = i_sfr_wr && (i_sfr_addr == PEND_LOW_ADDR);
	wire wr_pend_high = i_sfr_wr && (i_sfr_addr == PEND_HIGH_ADDR);
	wire wr_sel       = i_sfr_wr && (i_sfr_addr == SHARED_SEL_ADDR);
	wire wr_ctrl      = i_sfr_wr && (i_sfr_addr == TRAP_CTRL_ADDR);

	wire ext0_pin_enable       = watchdog_control_one[EXT0_EN_BIT];
	wire ram_fetch_trap_enable = watchdog_control_one[RAM_TRAP_EN_BIT];
	wire wdog_response_select  = watchdog_control_one[WDOG_RESP_BIT];
	wire trap_response_select  = watchdog_control_one[TRAP_RESP_BIT];

	wire shared_select_level8  = shared_source_selector[SEL_L8_BIT];
	wire shared_select_level9  = shared_source_selector[SEL_L9_BIT];
	wire shared_select_level13 = shared_source_selector[SEL_L13_BIT];
	wire shared_select_level14 = shared_source_selector[SEL_L14_BIT];
	wire shared_select_level15 = shared_source_selector[SEL_L15_BIT];

	// [R18] Fetch area trap.
	wire fetch_trap = i_fetch_valid && (in_area(i_fetch_addr, SFR_AREA_LO, SFR_AREA_HI)
		|| in_area(i_fetch_addr, BANK_AREA_LO, BANK_AREA_HI)
		|| (ram_fetch_trap_enable && in_area(i_fetch_addr, RAM_AREA_LO, RAM_AREA_HI)));

	// [R19] Address trap response.
	wire addr_trap_source = fetch_trap && !trap_response_select;
	wire addr_trap_reset  = fetch_trap && trap_response_select;
	// [R20] Watchdog trap response.
	wire wdog_trap_int    = i_wdog_trap_source && !wdog_response_select;
	wire wdog_trap_reset  = i_wdog_trap_source && wdog_response_select;
	wire trap_reset_req   = addr_trap_reset || wdog_trap_reset;

	// [R17] Shared level routing.
	wire src_level8  = shared_select_level8  ? pin_edge[2] : i_periph_req[P_TBT];
	wire src_level9  = shared_select_level9  ? pin_edge[3] : i_periph_req[P_TC1];
	wire src_level13 = shared_select_level13 ? pin_edge[4] : i_periph_req[P_SIO1];
	wire src_level14 = shared_select_level14 ? pin_edge[5] : i_periph_req[P_TRX];
	wire src_level15 = shared_select_level15 ? i_periph_req[P_SIO2] : i_periph_req[P_ADC];

	// [R3] Hardware set requests per level.
	// [R9] Bits 0 and 1 never latch.
	wire [15:0] set_vec = {
		src_level15,
		src_level14,
		src_level13,
		i_periph_req[P_TC2],
		i_periph_req[P_TC6],
		i_periph_req[P_TC3],
		src_level9,
		src_level8,
		i_periph_req[P_TC5],
		i_periph_req[P_TC4],
		pin_edge[1],
		pin_edge[0],
		wdog_trap_int,
		addr_trap_source,
		2'b00
	};

	// [R6] Software clear mask, zero clears.
	// [R7] A one written keeps the bit.
	wire [15:0] write_keep = {
		wr_pend_high ? i_sfr_wdata : 8'hFF,
		wr_pend_low  ? i_sfr_wdata : 8'hFF
	};

	wire accept_fire = i_irq_accept && o_irq_valid;
	// [R4] Clear the accepted level.
	wire [15:0] accept_clear = accept_fire ? (16'h0001 << o_irq_level) : 16'h0000;

	// Set wins over a clear in the same cycle, so no request is lost.
	wire [15:0] next_pending = ((pending_request_latch & write_keep & ~accept_clear)
		| set_vec) & 16'hFFFC;

	// [R1] One candidate bit per vector level.
	// [R2] Four traps maskless, the rest masked.
	// [R24] Traps accepted regardless of enables.
	// [R12] Maskable levels need master and level enable.
	// [R15] External 0 also needs its pin enable.
	wire        master_en    = o_master_accept_enable;
	wire        soft_trap    = i_software_trap_source || i_bad_opcode_source;
	wire [15:0] candidates   = {
		pending_request_latch[15:5] & level_accept_enable[15:5] & {11{master_en}},
		pending_request_latch[4] & level_accept_enable[4] & master_en & ext0_pin_enable,
		pending_request_latch[3:2],
		1'b0,
		soft_trap
	};
	assign pick.candidates = candidates;

	// [R14] Fixed vectors.
	// [R16] Levels step down by two.
	wire [15:0] next_vector = (pick.level == 4'(LVL_SOFT)) ? SOFT_VECTOR
		: VECTOR_TOP - {11'h000, pick.level, 1'b0};

	// [R22] Master enable: acceptance clears, return restores the stacked copy.
	// [R23] Master enable at bit 0 of the low enable register.
	wire next_master = accept_fire ? 1'b0
		: i_return_from_interrupt ? i_stacked_master_enable
		: i_mask_all_op ? 1'b0
		: i_unmask_all_op ? 1'b1
		: wr_en_low ? i_sfr_wdata[MASTER_EN_BIT]
		: master_en;

	// [R8] Read back of current state.
	wire [7:0] read_mux =
		(i_sfr_addr == EN_LOW_ADDR)     ? {level_accept_enable[7:4], 3'b000, master_en}
		: (i_sfr_addr == EN_HIGH_ADDR)  ? level_accept_enable[15:8]
		: (i_sfr_addr == PEND_LOW_ADDR) ? pending_request_latch[7:0]
		: (i_sfr_addr == PEND_HIGH_ADDR) ? pending_request_latch[15:8]
		: (i_sfr_addr == SHARED_SEL_ADDR) ? shared_source_selector
		: (i_sfr_addr == TRAP_CTRL_ADDR) ? {4'h0, watchdog_control_one}
		: 8'h00;

	// [R5] Reset clears every latch.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pending_request_latch <= PEND_RESET;
		end else if (i_ce) begin
			pending_request_latch <= next_pending;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_master_accept_enable <= MASTER_EN_RESET;
			level_accept_enable    <= LEVEL_EN_RESET;
			shared_source_selector <= SHARED_SEL_RESET;
			watchdog_control_one   <= TRAP_CTRL_RESET;
		end else if (i_ce) begin
			o_master_accept_enable <= next_master;
			if (wr_en_low) begin
				level_accept_enable[7:4] <= i_sfr_wdata[7:4];
			end
			if (wr_en_high) begin
				level_accept_enable[15:8] <= i_sfr_wdata;
			end
			if (wr_sel) begin
				shared_source_selector <= i_sfr_wdata & SHARED_SEL_MASK;
			end
			if (wr_ctrl) begin
				watchdog_control_one <= i_sfr_wdata[3:0];
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_ce && i_sfr_rd) begin
			o_sfr_rdata <= read_mux;
		end
	end

	// [R13] Lowest set candidate wins; traps ordered by index only.
	// [R25] Presented each cycle until the core accepts.
	// The request drops in the accept cycle so the cleared latch is never seen twice.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_valid  <= 1'b0;
			o_irq_vector <= RESET_VECTOR;
			o_irq_level  <= 4'h0;
		end else if (i_ce) begin
			o_irq_valid  <= pick.found && !accept_fire;
			o_irq_vector <= next_vector;
			o_irq_level  <= pick.level;
		end
	end

	// [R18] Trap reset held for the bounded count.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			trap_state   <= ST_IDLE;
			trap_count   <= 5'h00;
			o_trap_reset <= 1'b0;
		end else if (i_ce) begin
			unique case (trap_state)
				ST_IDLE: begin
					if (trap_reset_req) begin
						trap_state   <= ST_HOLD;
						trap_count   <= TRAP_RESET_CYCLES - 5'h01;
						o_trap_reset <= 1'b1;
					end
				end
				ST_HOLD: begin
					if (trap_count == 5'h00) begin
						trap_state   <= ST_IDLE;
						o_trap_reset <= 1'b0;
					end else begin
						trap_count <= trap_count - 5'h01;
					end
				end
				default: begin
					trap_state   <= ST_IDLE;
					o_trap_reset <= 1'b0;
				end
			endcase
		end
	end

endmodule

// *** ilu_props.sv ***
`timescale 1ns/1ns
module ilu_props (
	// Clock and reset.
	input wire logic        i_mclk,
	input wire logic        i_rst,
	// Core side.
	input wire logic        i_fetch_valid,
	input wire logic [15:0] i_fetch_addr,
	input wire logic        i_wdog_trap_source,
	input wire logic        i_irq_accept,
	input wire logic        i_return_from_interrupt,
	input wire logic        i_stacked_master_enable,
	input wire logic        o_irq_valid,
	input wire logic [15:0] o_irq_vector,
	input wire logic [3:0]  o_irq_level,
	input wire logic        o_master_accept_enable,
	input wire logic        o_trap_reset
);
	logic [5:0] hold_cnt;
	wire        trap_hit = (i_fetch_valid && i_fetch_addr <= 16'h0FFF) || i_wdog_trap_source;
	wire [15:0] exp_vec = (o_irq_level == 4'h0) ? 16'hFFFC :
		16'hFFFE - {11'h000, o_irq_level, 1'b0};
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence taken_s;
		o_irq_valid && i_irq_accept;
	endsequence
	sequence masked_taken_s;
		taken_s ##0 o_irq_level >= 4'h4;
	endsequence
	// A counter keeps the long hold out of a repetition operator.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			hold_cnt <= 6'h00;
		else
			hold_cnt <= o_trap_reset ? hold_cnt + 6'h01 : 6'h00;
	end
	accept_master_a: assert property (taken_s |=> !o_master_accept_enable)
		else $error("master enable kept after accept");
	accept_drop_a: assert property (masked_taken_s |=> !o_irq_valid)
		else $error("request kept after accept");
	reset_state_a: assert property ($fell(i_rst) |->
		!o_irq_valid && !o_master_accept_enable && o_irq_vector == 16'hFFFE)
		else $error("bad state after reset");
	vector_map_a: assert property (o_irq_valid |-> o_irq_vector == exp_vec)
		else $error("vector does not match level");
	mask_gate_a: assert property (o_irq_valid && o_irq_level >= 4'h4 |->
		$past(o_master_accept_enable))
		else $error("maskable request without master enable");
	trap_cause_a: assert property ($rose(o_trap_reset) |-> $past(trap_hit))
		else $error("trap reset without cause");
	trap_len_a: assert property ($fell(o_trap_reset) |-> hold_cnt == 6'h18)
		else $error("trap reset length wrong");
	return_load_a: assert property (i_return_from_interrupt &&
		!(o_irq_valid && i_irq_accept) |=> o_master_accept_enable == $past(i_stacked_master_enable))
		else $error("return did not restore master enable");
	nmi_hold_a: assert property (o_irq_valid && o_irq_level inside {4'h2, 4'h3} &&
		!i_irq_accept |=> o_irq_valid)
		else $error("trap request withdrawn");
endmodule

bind interrupt_latch_unit ilu_props u_props (
	.i_mclk, .i_rst, .i_fetch_valid, .i_fetch_addr, .i_wdog_trap_source, .i_irq_accept,
	.i_return_from_interrupt, .i_stacked_master_enable, .o_irq_valid, .o_irq_vector,
	.o_irq_level, .o_master_accept_enable, .o_trap_reset
);

// *** core_model.sv ***
`timescale 1ns/1ns
module core_model (
	// Clock and reset.
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	// Request from the block and test control.
	input  wire logic        i_irq_valid,
	input  wire logic [15:0] i_irq_vector,
	input  wire logic        i_master,
	input  wire logic        i_go,
	input  wire logic [3:0]  i_delay,
	// Answer to the block and record.
	output logic             o_accept,
	output logic             o_stacked,
	output logic      [15:0] o_last_vector,
	output logic      [7:0]  o_taken
);
	logic [3:0] wait_cnt;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_accept <= 1'b0;
			o_stacked <= 1'b0;
			o_last_vector <= 16'h0000;
			o_taken <= 8'h00;
			wait_cnt <= 4'h0;
		end else if (o_accept) begin
			o_accept <= 1'b0;
			o_stacked <= i_master;
			o_last_vector <= i_irq_vector;
			o_taken <= o_taken + 8'h01;
		end else if (i_go && i_irq_valid && wait_cnt == i_delay) begin
			o_accept <= 1'b1;
			wait_cnt <= 4'h0;
		end else if (i_go && i_irq_valid) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  i_sfr_addr = 8'h00;
	logic        i_sfr_wr = 1'b0;
	logic        i_sfr_rd = 1'b0;
	logic [7:0]  i_sfr_wdata = 8'h00;
	logic        i_fetch_valid = 1'b0;
	logic [15:0] i_fetch_addr = 16'h1000;
	logic        i_software_trap_source = 1'b0;
	logic        i_bad_opcode_source = 1'b0;
	logic [2:0]  core_op = 3'h0;
	logic [5:0]  i_int_pin = 6'h21;
	logic [10:0] i_periph_req = 11'h000;
	logic        i_wdog_trap_source = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  delay = 4'h0;
	wire logic   i_irq_accept, i_stacked_master_enable;
	wire logic   o_irq_valid, o_master_accept_enable, o_trap_reset;
	wire [15:0]  o_irq_vector, last_vec;
	wire [7:0]   o_sfr_rdata, taken;
	wire [3:0]   o_irq_level;
	int          bad_count = 0;
	int          total_checks = 0;
	int          n;
	always #25 i_mclk = ~i_mclk;
	interrupt_latch_unit u_dut (
		.i_mclk, .i_rst, .i_ce(1'b1), .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
		.o_sfr_rdata, .i_fetch_valid, .i_fetch_addr, .i_software_trap_source,
		.i_bad_opcode_source, .i_mask_all_op(core_op[2]), .i_unmask_all_op(core_op[1]),
		.i_return_from_interrupt(core_op[0]), .i_stacked_master_enable, .i_irq_accept,
		.i_int_pin, .i_periph_req, .i_wdog_trap_source, .o_irq_valid, .o_irq_vector,
		.o_irq_level, .o_master_accept_enable, .o_trap_reset
	);
	core_model u_core (
		.i_mclk, .i_rst, .i_irq_valid(o_irq_valid), .i_irq_vector(o_irq_vector),
		.i_master(o_master_accept_enable), .i_go(go), .i_delay(delay),
		.o_accept(i_irq_accept), .o_stacked(i_stacked_master_enable),
		.o_last_vector(last_vec), .o_taken(taken)
	);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(negedge i_mclk);
		i_sfr_wr = 1'b0;
		@(negedge i_mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(negedge i_mclk);
		i_sfr_rd = 1'b0;
		@(negedge i_mclk);
		check(name, {8'h00, exp}, {8'h00, o_sfr_rdata});
	endtask
	task automatic op(input logic [2:0] v);
		core_op = v;
		@(negedge i_mclk);
		core_op = 3'h0;
		@(negedge i_mclk);
	endtask
	task automatic fire(input logic [10:0] m);
		i_periph_req = m;
		@(negedge i_mclk);
		i_periph_req = 11'h000;
		@(negedge i_mclk);
	endtask
	task automatic pins(input logic [5:0] p);
		i_int_pin = p;
		repeat (6) @(negedge i_mclk);
	endtask
	task automatic take(input logic [15:0] exp, input string name);
		int k = 0;
		n = int'(taken);
		go = 1'b1;
		while (int'(taken) == n && k < 40) begin
			@(negedge i_mclk);
			k++;
		end
		go = 1'b0;
		if (k == 40) begin
			bad_count++;
			$display("ERROR %s expected accept seen none", name);
			report_and_stop();
		end
		check(name, exp, last_vec);
	endtask
	initial begin
		repeat (5) @(negedge i_mclk);
		i_rst = 1'b0;
		@(negedge i_mclk);
		rd(8'h3A, 8'h00, "enable_low");
		rd(8'h3C, 8'h00, "pend_low");
		rd(8'h3D, 8'h00, "pend_high");
		rd(8'h38, 8'h0C, "trap_ctrl");
		rd(8'h39, 8'h00, "unmapped");
		$display("test reset_values done");
		wr(8'h3A, 8'hF0);
		wr(8'h3B, 8'hFF);
		fire(11'h009);
		rd(8'h3C, 8'h40, "pend_six");
		rd(8'h3D, 8'h02, "pend_nine");
		check("valid_masked", 16'h0000, {15'h0, o_irq_valid});
		wr(8'h3C, 8'hFF);
		rd(8'h3C, 8'h40, "write_one");
		wr(8'h3C, 8'hBF);
		rd(8'h3C, 8'h00, "write_zero");
		fire(11'h009);
		op(3'b010);
		take(16'hFFF2, "first_vector");
		check("master_cleared", 16'h0000, {15'h0, o_master_accept_enable});
		rd(8'h3C, 8'h00, "accept_clear");
		op(3'b001);
		take(16'hFFEC, "nested_vector");
		$display("test latch_priority done");
		for (int lv = 6; lv < 16; lv++) begin
			fire(11'(1) << (lv - 6));
			op(3'b010);
			take(16'hFFFE - 16'(2 * lv), "level_vector");
		end
		pins(6'h23);
		op(3'b010);
		take(16'hFFF4, "pin_one");
		pins(6'h25);
		rd(8'h3D, 8'h00, "unselected_pin");
		pins(6'h21);
		wr(8'h3E, 8'h80);
		fire(11'h004);
		pins(6'h25);
		rd(8'h3D, 8'h01, "selected_pin");
		wr(8'h3D, 8'h00);
		$display("test shared_levels done");
		pins(6'h24);
		op(3'b010);
		repeat (4) @(negedge i_mclk);
		check("ext0_gated", 16'h0000, {15'h0, o_irq_valid});
		op(3'b100);
		wr(8'h38, 8'h0D);
		op(3'b010);
		take(16'hFFF6, "ext0_vector");
		pins(6'h21);
		$display("test ext0 done");
		delay = 4'h3;
		wr(8'h38, 8'h08);
		fire(11'h000);
		i_wdog_trap_source = 1'b1;
		@(negedge i_mclk);
		i_wdog_trap_source = 1'b0;
		take(16'hFFF8, "wdog_vector");
		i_fetch_valid = 1'b1;
		i_fetch_addr = 16'h0010;
		@(negedge i_mclk);
		i_fetch_valid = 1'b0;
		n = 0;
		repeat (40) begin
			n += int'(o_trap_reset);
			@(negedge i_mclk);
		end
		check("trap_hold", 16'd24, 16'(n));
		wr(8'h38, 8'h00);
		i_fetch_valid = 1'b1;
		i_fetch_addr = 16'h0F90;
		@(negedge i_mclk);
		i_fetch_valid = 1'b0;
		take(16'hFFFA, "addr_trap");
		for (int i = 0; i < 2; i++) begin
			{i_software_trap_source, i_bad_opcode_source} = (i == 0) ? 2'b10 : 2'b01;
			take(16'hFFFC, "soft_trap");
			{i_software_trap_source, i_bad_opcode_source} = 2'b00;
			repeat (3) @(negedge i_mclk);
		end
		$display("test traps done");
		report_and_stop();
	end
endmodule
